// *** cmd_frame_interp.sv ***
/*
  Slave-side frame interpreter for a binary motion command protocol: collects
  command frames from a byte stream, checks address and, on a serial link, checksum, hands the
  command to an executor, and streams back one reply per accepted frame.
  Assumes byte stream and executor run on clk_sys; addresses and link mode
  are static configuration from the same clock domain.
*/
`timescale 1ns/10ps
module cmd_frame_interp
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic can_mode,
  input wire logic [frame_pkg::BYTE_W-1:0] own_addr,
  input wire logic [frame_pkg::BYTE_W-1:0] host_addr,
  input wire logic [frame_pkg::BYTE_W-1:0] rx_data,
  input wire logic rx_sof,
  input wire logic [frame_pkg::BYTE_W-1:0] rx_id,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic cmd_valid,
  output logic [frame_pkg::BYTE_W-1:0] cmd_code,
  output logic [frame_pkg::BYTE_W-1:0] cmd_type,
  output logic [frame_pkg::BYTE_W-1:0] cmd_bank,
  output logic [frame_pkg::VALUE_W-1:0] cmd_value,
  input wire logic exe_done,
  input wire logic [frame_pkg::BYTE_W-1:0] exe_status,
  input wire logic [frame_pkg::VALUE_W-1:0] exe_value,
  output logic [frame_pkg::BYTE_W-1:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [frame_pkg::BYTE_W-1:0] tx_id
);
  import frame_pkg::*;

  ctl_state_type state_ff;
  ctl_state_type nxt_state;
  logic [BYTE_W-1:0] frame_ff [POS_CODE:POS_VAL0];
  logic [POS_W-1:0] pos_ff;
  logic [BYTE_W-1:0] sum_ff;
  logic cmd_valid_ff;
  logic rx_ready_ff;
  logic [BYTE_W-1:0] addr_ff;
  logic [BYTE_W-1:0] rep_status_ff;
  logic [VALUE_W-1:0] rep_value_ff;
  logic [POS_W-1:0] tx_pos_ff;
  logic [BYTE_W-1:0] tx_sum_ff;
  logic [BYTE_W-1:0] tx_id_ff;

  logic take;
  logic [POS_W-1:0] first_pos;
  logic [POS_W-1:0] cur_pos;
  logic [POS_W-1:0] last_pos;
  logic [BYTE_W-1:0] sum_base;
  logic [BYTE_W-1:0] sum_now;
  logic [BYTE_W-1:0] rx_addr;
  logic frame_end;
  logic addr_hit;
  logic sum_ok;
  logic accept_ok;
  logic accept_bad;
  logic [BYTE_W-1:0] rep_byte;
  logic rep_push;
  logic rep_last;
  logic rep_active;
  logic buf_in_ready;
  logic [BYTE_W-1:0] buf_out_data;
  logic buf_out_valid;

  assign take = rx_valid & rx_ready_ff;
  assign first_pos = can_mode ? POS_CODE : POS_ADDR;
  assign cur_pos = rx_sof ? first_pos : pos_ff;
  assign last_pos = can_mode ? POS_VAL0 : POS_SUM;
  assign sum_base = (cur_pos == POS_ADDR) ? BYTE_ZERO : sum_ff;
  assign sum_now = BYTE_W'(sum_base + rx_data);
  assign rx_addr = (cur_pos == POS_ADDR) ? rx_data : addr_ff;
  assign frame_end = take & (cur_pos == last_pos);
  // On CAN the identifier carries the module address and the bus CRC replaces the checksum.
  assign addr_hit = can_mode ? (rx_id == own_addr) : (addr_ff == own_addr);
  assign sum_ok = can_mode | (rx_data == sum_ff);
  assign accept_ok = frame_end & addr_hit & sum_ok;
  assign accept_bad = frame_end & addr_hit & ~sum_ok;
  assign rep_last = (tx_pos_ff == (can_mode ? REP_VAL0 : REP_SUM));
  assign rep_active = (state_ff == ST_REPLY);
  assign rep_push = rep_active & buf_in_ready;

  // Reply byte for the current slot; value bytes leave most significant first.
  assign rep_byte = (tx_pos_ff == REP_HOST) ? host_addr :
                    (tx_pos_ff == REP_OWN) ? own_addr :
                    (tx_pos_ff == REP_STATUS) ? rep_status_ff :
                    (tx_pos_ff == REP_CODE) ? frame_ff[POS_CODE] :
                    (tx_pos_ff == REP_VAL3) ? rep_value_ff[31:24] :
                    (tx_pos_ff == REP_VAL2) ? rep_value_ff[23:16] :
                    (tx_pos_ff == REP_VAL1) ? rep_value_ff[15:8] :
                    (tx_pos_ff == REP_VAL0) ? rep_value_ff[7:0] :
                    tx_sum_ff;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RECEIVE:
      begin
        if (accept_ok)
          nxt_state = ST_EXECUTE;
        else if (accept_bad)
          nxt_state = ST_REPLY;
      end
      ST_EXECUTE:
      begin
        if (exe_done)
          nxt_state = ST_REPLY;
      end
      ST_REPLY:
      begin
        if (rep_push & rep_last)
          nxt_state = ST_RECEIVE;
      end
      default:
        nxt_state = ST_RECEIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_ff <= ST_RECEIVE;
    else
      state_ff <= nxt_state;
  end

  // Input is refused outside the receive state, so a master that ignores the wait stalls instead of corrupting.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rx_ready_ff <= 1'b0;
    else
      rx_ready_ff <= (nxt_state == ST_RECEIVE);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pos_ff <= POS_ADDR;
      sum_ff <= BYTE_ZERO;
      addr_ff <= BYTE_ZERO;
    end
    else if (take)
    begin
      pos_ff <= (cur_pos == last_pos) ? first_pos : POS_W'(cur_pos + 1'b1);
      sum_ff <= sum_now;
      addr_ff <= rx_addr;
    end
    else if (state_ff != ST_RECEIVE)
      pos_ff <= first_pos;
  end

  genvar gi;
  generate
    for (gi = POS_CODE; gi <= POS_VAL0; gi++)
    begin : g_body
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
          frame_ff[gi] <= BYTE_ZERO;
        else if (take && cur_pos == gi)
          frame_ff[gi] <= rx_data;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cmd_valid_ff <= 1'b0;
    else
      cmd_valid_ff <= accept_ok;
  end

  // The executor reports 100, 101 or an error code 2 to 6; this block only injects code 1.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rep_status_ff <= ST_OK;
      rep_value_ff <= VALUE_ZERO;
    end
    else if (accept_bad)
    begin
      rep_status_ff <= ST_BAD_SUM;
      rep_value_ff <= VALUE_ZERO;
    end
    else if (state_ff == ST_EXECUTE && exe_done)
    begin
      rep_status_ff <= exe_status;
      rep_value_ff <= exe_value;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_pos_ff <= REP_HOST;
      tx_sum_ff <= BYTE_ZERO;
      tx_id_ff <= BYTE_ZERO;
    end
    else if (state_ff != ST_REPLY)
    begin
      tx_pos_ff <= can_mode ? REP_OWN : REP_HOST;
      tx_sum_ff <= BYTE_ZERO;
      tx_id_ff <= host_addr;
    end
    else if (rep_push)
    begin
      tx_pos_ff <= POS_W'(tx_pos_ff + 1'b1);
      tx_sum_ff <= BYTE_W'(tx_sum_ff + rep_byte);
    end
  end

  reply_skid u_skid
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_data(rep_byte),
    .in_valid(rep_active),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(tx_ready)
  );

  assign rx_ready = rx_ready_ff;
  assign cmd_valid = cmd_valid_ff;
  assign cmd_code = frame_ff[POS_CODE];
  assign cmd_type = frame_ff[POS_TYPE];
  assign cmd_bank = frame_ff[POS_BANK];
  assign cmd_value = {frame_ff[POS_VAL3], frame_ff[POS_VAL2], frame_ff[POS_VAL1], frame_ff[POS_VAL0]};
  assign tx_data = buf_out_data;
  assign tx_valid = buf_out_valid;
  assign tx_id = tx_id_ff;

endmodule

// *** frame_pkg.sv ***
/*
  Constants shared by the command frame interpreter and its output buffer:
  field widths, byte positions within a frame, and reply status codes.
  Assumes nothing of its surroundings.
*/
package frame_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned VALUE_W = 32;
  localparam int unsigned POS_W = 4;

  // Byte positions inside a serial frame; a CAN frame uses the same slots minus the first and last.
  localparam logic [3:0] POS_ADDR = 4'h0;
  localparam logic [3:0] POS_CODE = 4'h1;
  localparam logic [3:0] POS_TYPE = 4'h2;
  localparam logic [3:0] POS_BANK = 4'h3;
  localparam logic [3:0] POS_VAL3 = 4'h4;
  localparam logic [3:0] POS_VAL2 = 4'h5;
  localparam logic [3:0] POS_VAL1 = 4'h6;
  localparam logic [3:0] POS_VAL0 = 4'h7;
  localparam logic [3:0] POS_SUM = 4'h8;

  // Reply slots on a serial link.
  localparam logic [3:0] REP_HOST = 4'h0;
  localparam logic [3:0] REP_OWN = 4'h1;
  localparam logic [3:0] REP_STATUS = 4'h2;
  localparam logic [3:0] REP_CODE = 4'h3;
  localparam logic [3:0] REP_VAL3 = 4'h4;
  localparam logic [3:0] REP_VAL2 = 4'h5;
  localparam logic [3:0] REP_VAL1 = 4'h6;
  localparam logic [3:0] REP_VAL0 = 4'h7;
  localparam logic [3:0] REP_SUM = 4'h8;

  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] VALUE_ZERO = 32'h00000000;

  typedef enum logic [1:0]
  {
    ST_RECEIVE = 2'b00,
    ST_EXECUTE = 2'b01,
    ST_REPLY = 2'b11
  } ctl_state_type;

endpackage

// *** reply_skid.sv ***
/*
  Two-entry buffer with valid and ready on both sides, outputs from flops.
  Assumes a consumer on the same clock that may stall at any time.
*/
`timescale 1ns/10ps
module reply_skid
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [frame_pkg::BYTE_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [frame_pkg::BYTE_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import frame_pkg::*;

  logic [BYTE_W-1:0] head_ff;
  logic head_valid_ff;
  logic [BYTE_W-1:0] spare_ff;
  logic spare_valid_ff;
  logic push;
  logic head_free;
  logic [BYTE_W-1:0] nxt_head;
  logic nxt_head_valid;
  logic [BYTE_W-1:0] nxt_spare;
  logic nxt_spare_valid;

  // Ready depends only on the spare slot, so no path runs from out_ready to in_ready.
  assign in_ready = ~spare_valid_ff;
  assign push = in_valid & in_ready;
  assign head_free = ~head_valid_ff | out_ready;
  assign nxt_head = !head_free ? head_ff : (spare_valid_ff ? spare_ff : in_data);
  assign nxt_head_valid = !head_free | spare_valid_ff | push;
  assign nxt_spare = (push & !head_free) ? in_data : spare_ff;
  assign nxt_spare_valid = head_free ? 1'b0 : (spare_valid_ff | push);
  assign out_data = head_ff;
  assign out_valid = head_valid_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      head_ff <= BYTE_ZERO;
      head_valid_ff <= 1'b0;
      spare_ff <= BYTE_ZERO;
      spare_valid_ff <= 1'b0;
    end
    else
    begin
      head_ff <= nxt_head;
      head_valid_ff <= nxt_head_valid;
      spare_ff <= nxt_spare;
      spare_valid_ff <= nxt_spare_valid;
    end
  end

endmodule

// *** cmd_frame_interp_asserts.sv ***
/*
  Port-level checker for the command frame interpreter.
  Assumes a single clk_sys domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module cmd_frame_checker
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic can_mode,
  input wire logic [frame_pkg::BYTE_W-1:0] own_addr,
  input wire logic [frame_pkg::BYTE_W-1:0] host_addr,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic cmd_valid,
  input wire logic exe_done,
  input wire logic [frame_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [frame_pkg::BYTE_W-1:0] tx_id
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_cmd_quiet: assert property (cmd_valid |-> !rx_ready && !tx_valid)
    else $error("receiver open or reply busy at command strobe");
  a_cmd_taken: assert property (cmd_valid |-> $past(rx_valid && rx_ready))
    else $error("command strobe without a byte taken before it");
  a_reply_lat: assert property (cmd_valid ##[0:8] exe_done |-> ##2 tx_valid)
    else $error("reply did not start two cycles after execution");
  a_first_host: assert property ($rose(tx_valid) && !can_mode |-> tx_data == host_addr)
    else $error("serial reply does not open with reply address");
  a_first_own: assert property ($rose(tx_valid) && can_mode |-> tx_data == own_addr)
    else $error("CAN reply does not open with module address");
  a_tx_ident: assert property (tx_valid |-> tx_id == host_addr)
    else $error("reply identifier differs from reply address");
  a_tx_quiet: assert property (rx_ready && !rx_valid && !tx_valid |=> !tx_valid)
    else $error("transmit without a received command");
endmodule

bind cmd_frame_interp cmd_frame_checker chk_i (.clk_sys, .resetn, .can_mode, .own_addr, .host_addr,
  .rx_valid, .rx_ready, .cmd_valid, .exe_done, .tx_data, .tx_valid, .tx_ready, .tx_id);

// *** host_sink.sv ***
/*
  Bus master model on the reply side: collects reply bytes and may stall.
  Assumes the reply stream runs on clk_sys.
*/
`timescale 1ns/10ps
module host_sink
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  input wire logic [frame_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [frame_pkg::BYTE_W-1:0] got[$];
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
      begin
        got.push_back(tx_data);
      end
      tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule

// *** test_motion_command_frame_interpreter.sv ***
/*
  Self-checking bench: sends command frames, plays the executor and checks replies.
  Assumes the interpreter, its checker and the host_sink model.
*/
`timescale 1ns/10ps
module test_motion_command_frame_interpreter;
  import frame_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic can_mode = 1'b0;
  logic [7:0] own_addr = 8'h05;
  logic [7:0] host_addr = 8'h02;
  logic [7:0] rx_data = 8'h00;
  logic rx_sof = 1'b0;
  logic [7:0] rx_id = 8'h00;
  logic rx_valid = 1'b0;
  logic exe_done = 1'b0;
  logic [7:0] exe_status = 8'h00;
  logic [31:0] exe_value = 32'h0;
  logic stall = 1'b0;
  logic rx_ready, cmd_valid, tx_valid, tx_ready;
  logic [7:0] cmd_code, cmd_type, cmd_bank, tx_data, tx_id;
  logic [31:0] cmd_value;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] tbl[7] = '{ST_OK, ST_STORED, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VALUE, ST_LOCKED, ST_NOT_AVAIL};
  int i, c;

  always #2.5 clk_sys = ~clk_sys;

  cmd_frame_interp DUT (.clk_sys, .resetn, .can_mode, .own_addr, .host_addr, .rx_data, .rx_sof, .rx_id,
    .rx_valid, .rx_ready, .cmd_valid, .cmd_code, .cmd_type, .cmd_bank, .cmd_value, .exe_done,
    .exe_status, .exe_value, .tx_data, .tx_valid, .tx_ready, .tx_id);
  host_sink host (.clk_sys, .resetn, .stall, .tx_data, .tx_valid, .tx_ready);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Modulo-256 sum of the eight bytes that precede a checksum slot.
  function automatic logic [7:0] sum8(input logic [7:0] v[9]);
    logic [7:0] s;
    s = 8'h00;
    for (int m = 0; m < 8; m++)
      s = s + v[m];
    return s;
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic frame(input bit can, input logic [7:0] adr, input logic [7:0] adj, input logic [7:0] st);
    logic [7:0] b[9];
    logic [7:0] e[9];
    logic [31:0] val, rv;
    bit hit, bad;
    int n, k;
    val = $urandom();
    rv = $urandom();
    hit = (adr === own_addr);
    bad = (adj !== 8'h00);
    n = can ? 7 : 9;
    b[0] = adr;
    for (k = 1; k < 4; k++) b[k] = 8'($urandom());
    e[0] = host_addr;
    e[1] = own_addr;
    e[2] = bad ? ST_BAD_SUM : st;
    e[3] = b[1];
    for (k = 0; k < 4; k++)
    begin
      b[4+k] = val[31-8*k -: 8];
      e[4+k] = bad ? 8'h00 : rv[31-8*k -: 8];
    end
    b[8] = adj + sum8(b);
    e[8] = sum8(e);
    can_mode <= can;
    rx_id <= adr;
    for (k = 0; k < n; k++)
    begin
      rx_data <= b[k + (can ? 1 : 0)];
      // The start marker is sometimes left out so that the counter's own wrap frames the bytes.
      // It is always sent when the mode changes, since the counter then still points into the old framing.
      rx_sof <= (k == 0) && (can_mode != can || $urandom_range(1));
      rx_valid <= 1'b1;
      @(posedge clk_sys);
      while (!rx_ready) @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    @(posedge clk_sys);
    chk(cmd_valid, 32'(hit && !bad));
    if (hit && !bad)
    begin
      chk({8'h00, cmd_code, cmd_type, cmd_bank}, {8'h00, b[1], b[2], b[3]});
      chk(cmd_value, val);
      repeat ($urandom_range(3)) @(posedge clk_sys);
      exe_done <= 1'b1;
      exe_status <= st;
      exe_value <= rv;
      @(posedge clk_sys);
      exe_done <= 1'b0;
    end
    k = 0;
    while (hit && host.got.size() < n && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (20) @(posedge clk_sys);
    chk(host.got.size(), hit ? n : 0);
    chk(rx_ready, 1);
    foreach (host.got[j]) chk(host.got[j], e[j + (can ? 1 : 0)]);
    if (can && hit) chk(tx_id, host_addr);
    host.got.delete();
  endtask

  initial
  begin
    #(5 * 60000);
    err_count++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h6425));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 40; i++)
    begin
      stall <= (i > 10) && $urandom_range(1);
      c = $urandom_range(1);
      if (i < 7)
        frame(0, own_addr, 8'h00, tbl[i]);
      else if (i == 7)
        frame(0, own_addr, 8'h5a, ST_OK);
      else if (i < 10)
        frame(i == 9, own_addr ^ 8'h80, 8'h00, ST_OK);
      else if (i == 10)
        frame(1, own_addr, 8'h00, ST_STORED);
      else
        frame(c, $urandom_range(3) ? own_addr : own_addr + 8'h01,
          (c || $urandom_range(3)) ? 8'h00 : 8'($urandom_range(255, 1)), tbl[$urandom_range(6)]);
    end
    conclude();
  end
endmodule
